//--- cilc_pkg.sv
package cilc_pkg;

  // ----------------------------------------
  // Bus geometry and source count
  // ----------------------------------------
  localparam int unsigned CILC_AW = 16;
  localparam int unsigned CILC_DW = 16;
  localparam int unsigned CILC_NSRC = 3;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] CILC_OFS_STATUS = 16'h0042;
  localparam logic [15:0] CILC_OFS_CORE = 16'h0044;
  localparam logic [15:0] CILC_OFS_HOLD = 16'h0052;
  localparam logic [15:0] CILC_OFS_CTL1 = 16'h0080;
  localparam logic [15:0] CILC_OFS_CTL2 = 16'h0082;
  localparam logic [15:0] CILC_OFS_ISTAT = 16'h0084;
  localparam logic [15:0] CILC_OFS_IMASK = 16'h0086;
  localparam logic [15:0] CILC_OFS_PRIO = 16'h0088;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CILC_ST_DC_BIT = 8;
  localparam int unsigned CILC_ST_LVL_LSB = 5;
  localparam int unsigned CILC_CC_MSB_BIT = 3;
  localparam int unsigned CILC_C1_NEST_BIT = 15;
  localparam int unsigned CILC_C2_ALT_BIT = 15;
  localparam int unsigned CILC_C2_HOLD_BIT = 14;
  localparam int unsigned CILC_PR_STRIDE = 4;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] CILC_REG_RST = 16'h0000;
  localparam logic [2:0] CILC_LVL_RST = 3'h0;
  localparam logic [2:0] CILC_PRIO_RST = 3'h4;
  localparam logic [2:0] CILC_LVL_BLOCK = 3'h7;
  localparam logic [2:0] CILC_PRIO_OFF = 3'h0;

endpackage

//--- cilc_edge_if.sv
`timescale 1ns/1ps
interface cilc_edge_if #(parameter int N = 3);
  logic [N-1:0] edge_sel;
  logic [N-1:0] edge_hit;
  modport det (input edge_sel, output edge_hit);
  modport ctl (output edge_sel, input edge_hit);
endinterface

//--- cilc_edge.sv
`timescale 1ns/1ps
module cilc_edge #(
  parameter int N = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [N-1:0] pin,
  cilc_edge_if.det eif
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] prev_r;
  logic [1:0] warm_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // ----------------------------------------
  // Polarity-selected edge pulse
  // ----------------------------------------
  // Pipeline holds reset zeros for three edges; a pin that idles high
  // would otherwise look like a rising edge right after reset.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      warm_r <= 2'h0;
    else if (warm_r != 2'h3)
      warm_r <= warm_r + 2'h1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      eif.edge_hit <= '0;
    else if (warm_r != 2'h3)
      eif.edge_hit <= '0;
    else
      eif.edge_hit <= (eif.edge_sel & ~sync2_r & prev_r)
        | (~eif.edge_sel & sync2_r & ~prev_r);
  end

endmodule

//--- cilc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Priority level lives in status bits 7..5
// - Level code seven blocks every user interrupt
// - Core control bit extends level to four bits
// - Nesting disable makes level field read-only
// - Control two bit 15 picks alternate table
// - Control two bit 14 shows hold active
// - Edge select bits pick falling or rising
// - Reset clears status and core control
// - Unimplemented bits always read as zero
// - Source priority three bits, zero disables
module cilc_top
  import cilc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [CILC_AW-1:0] addr,
  input wire logic [CILC_DW-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [CILC_DW-1:0] rdata_r,
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  input wire logic ext_irq_two_pin,
  output logic irq_r,
  output logic accept_req_r,
  output logic [1:0] accept_src_r,
  output logic [2:0] accept_prio_r,
  output logic alternate_vector_select_r,
  output logic [3:0] cpu_level_r
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [2:0] cpu_priority_level_r;
  logic cpu_priority_msb_r;
  logic dc_r;
  logic [3:0] alu_flags_r;
  logic nesting_disable_r;
  logic [CILC_NSRC-1:0] edge_sel_r;
  logic [15:0] hold_cnt_r;
  logic [CILC_NSRC-1:0] int_stat_r;
  logic [CILC_NSRC-1:0] int_mask_r;
  logic [CILC_NSRC-1:0][2:0] src_prio_r;
  logic interrupt_hold_active;
  logic [CILC_DW-1:0] rd_nxt;
  logic best_vld;
  logic [1:0] best_src;
  logic [2:0] best_prio;
  logic take_nxt;
  logic [3:0] eff_level;

  cilc_edge_if #(.N(CILC_NSRC)) eif();

  cilc_edge #(
    .N(CILC_NSRC)
  ) u_edge (
    .clock(clock),
    .rst(rst),
    .pin({ext_irq_two_pin, ext_irq_one_pin, ext_irq_zero_pin}),
    .eif(eif)
  );

  assign eif.edge_sel = edge_sel_r;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] ofs,
    input logic stb);
    return stb && (a == ofs);
  endfunction

  function automatic logic [3:0] join_level(input logic msb, input logic [2:0] lvl);
    return {msb, lvl};
  endfunction

  assign eff_level = join_level(cpu_priority_msb_r, cpu_priority_level_r);
  assign interrupt_hold_active = (hold_cnt_r != 16'h0000);

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cpu_priority_level_r <= CILC_LVL_RST;
    else if (wr_hit(addr, CILC_OFS_STATUS, wr_en) && !nesting_disable_r)
      cpu_priority_level_r <= wdata[CILC_ST_LVL_LSB+:3];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dc_r <= 1'b0;
      alu_flags_r <= 4'h0;
    end
    else if (wr_hit(addr, CILC_OFS_STATUS, wr_en))
    begin
      dc_r <= wdata[CILC_ST_DC_BIT];
      alu_flags_r <= wdata[3:0];
    end
  end

  // ----------------------------------------
  // Core control and control one
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cpu_priority_msb_r <= 1'b0;
    else if (wr_hit(addr, CILC_OFS_CORE, wr_en))
      cpu_priority_msb_r <= wdata[CILC_CC_MSB_BIT];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      nesting_disable_r <= 1'b0;
    else if (wr_hit(addr, CILC_OFS_CTL1, wr_en))
      nesting_disable_r <= wdata[CILC_C1_NEST_BIT];
  end

  // ----------------------------------------
  // Control two
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      alternate_vector_select_r <= 1'b0;
      edge_sel_r <= '0;
    end
    else if (wr_hit(addr, CILC_OFS_CTL2, wr_en))
    begin
      alternate_vector_select_r <= wdata[CILC_C2_ALT_BIT];
      edge_sel_r <= wdata[CILC_NSRC-1:0];
    end
  end

  // ----------------------------------------
  // Interrupt hold counter
  // ----------------------------------------
  // Software may not rely on the reset value; clearing it keeps the
  // hold flag quiet after reset.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      hold_cnt_r <= CILC_REG_RST;
    else if (wr_hit(addr, CILC_OFS_HOLD, wr_en))
      hold_cnt_r <= wdata;
    else if (interrupt_hold_active)
      hold_cnt_r <= hold_cnt_r - 16'h0001;
  end

  // ----------------------------------------
  // Sticky edge flags, mask, priorities
  // ----------------------------------------
  // A new edge in the clearing cycle survives the clear.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      int_stat_r <= '0;
    else if (wr_hit(addr, CILC_OFS_ISTAT, wr_en))
      int_stat_r <= (int_stat_r & ~wdata[CILC_NSRC-1:0]) | eif.edge_hit;
    else
      int_stat_r <= int_stat_r | eif.edge_hit;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      int_mask_r <= '0;
    else if (wr_hit(addr, CILC_OFS_IMASK, wr_en))
      int_mask_r <= wdata[CILC_NSRC-1:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < CILC_NSRC; i++)
        src_prio_r[i] <= CILC_PRIO_RST;
    end
    else if (wr_hit(addr, CILC_OFS_PRIO, wr_en))
    begin
      for (int i = 0; i < CILC_NSRC; i++)
        src_prio_r[i] <= wdata[i*CILC_PR_STRIDE+:3];
    end
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  // Strict compare keeps the lowest index on equal priority, and a zero
  // priority can never beat the starting value.
  always_comb
  begin
    best_vld = 1'b0;
    best_src = 2'h0;
    best_prio = CILC_PRIO_OFF;
    for (int i = 0; i < CILC_NSRC; i++)
    begin
      if (int_stat_r[i] && int_mask_r[i] && (src_prio_r[i] > best_prio))
      begin
        best_vld = 1'b1;
        best_src = 2'(i);
        best_prio = src_prio_r[i];
      end
    end
  end

  assign take_nxt = best_vld && ({1'b0, best_prio} > eff_level)
    && (cpu_priority_level_r != CILC_LVL_BLOCK)
    && !interrupt_hold_active;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      accept_req_r <= 1'b0;
      accept_src_r <= 2'h0;
      accept_prio_r <= CILC_PRIO_OFF;
    end
    else
    begin
      accept_req_r <= take_nxt;
      accept_src_r <= take_nxt ? best_src : 2'h0;
      accept_prio_r <= take_nxt ? best_prio : CILC_PRIO_OFF;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
      cpu_level_r <= 4'h0;
    end
    else
    begin
      irq_r <= |(int_stat_r & int_mask_r);
      cpu_level_r <= eff_level;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb
  begin
    rd_nxt = '0;
    case (addr)
      CILC_OFS_STATUS:
      begin
        rd_nxt[CILC_ST_DC_BIT] = dc_r;
        rd_nxt[CILC_ST_LVL_LSB+:3] = cpu_priority_level_r;
        rd_nxt[3:0] = alu_flags_r;
      end
      CILC_OFS_CORE: rd_nxt[CILC_CC_MSB_BIT] = cpu_priority_msb_r;
      CILC_OFS_HOLD: rd_nxt = hold_cnt_r;
      CILC_OFS_CTL1: rd_nxt[CILC_C1_NEST_BIT] = nesting_disable_r;
      CILC_OFS_CTL2:
      begin
        rd_nxt[CILC_C2_ALT_BIT] = alternate_vector_select_r;
        rd_nxt[CILC_C2_HOLD_BIT] = interrupt_hold_active;
        rd_nxt[CILC_NSRC-1:0] = edge_sel_r;
      end
      CILC_OFS_ISTAT: rd_nxt[CILC_NSRC-1:0] = int_stat_r;
      CILC_OFS_IMASK: rd_nxt[CILC_NSRC-1:0] = int_mask_r;
      CILC_OFS_PRIO:
      begin
        for (int i = 0; i < CILC_NSRC; i++)
          rd_nxt[i*CILC_PR_STRIDE+:3] = src_prio_r[i];
      end
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_r <= '0;
    else
      rdata_r <= rd_en ? rd_nxt : '0;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_level_write_takes: assert property (
    (wr_en && addr == CILC_OFS_STATUS && !nesting_disable_r)
    |=> cpu_priority_level_r == $past(wdata[7:5]))
    else $error("level write not stored");

  a_level_seven_blocks: assert property (
    (cpu_priority_level_r == 3'h7) |=> !accept_req_r)
    else $error("accept while level code is seven");

  a_level_joined: assert property (
    ##1 cpu_level_r == {$past(cpu_priority_msb_r), $past(cpu_priority_level_r)})
    else $error("effective level not joined");

  a_level_write_locked: assert property (
    (wr_en && addr == CILC_OFS_STATUS && nesting_disable_r)
    |=> $stable(cpu_priority_level_r))
    else $error("level changed while nesting disabled");

  a_alt_table_sel: assert property (
    (wr_en && addr == CILC_OFS_CTL2)
    |=> alternate_vector_select_r == $past(wdata[15]))
    else $error("table select not stored");

  a_hold_flag_read: assert property (
    (rd_en && addr == CILC_OFS_CTL2)
    |=> rdata_r[14] == ($past(hold_cnt_r) != 16'h0000))
    else $error("hold flag wrong");

  a_edge_sets_flag: assert property (
    (eif.edge_hit[0] && !wr_en) |=> int_stat_r[0])
    else $error("edge did not set flag");

  a_reset_clears: assert property (
    $past(rst) |-> (cpu_priority_level_r == 3'h0 && !cpu_priority_msb_r))
    else $error("level not cleared by reset");

  a_unimpl_zero: assert property (
    (rd_en && (addr == CILC_OFS_STATUS || addr == CILC_OFS_CTL2))
    |=> (rdata_r[13:9] == 5'h00 && rdata_r[4] == 1'b0))
    else $error("unimplemented bits not zero");

  a_prio_off_never: assert property (
    accept_req_r |-> accept_prio_r != 3'h0)
    else $error("disabled source accepted");

  a_accept_above: assert property (
    accept_req_r |-> {1'b0, accept_prio_r} > $past(eff_level))
    else $error("accepted at or below cpu level");

  c_accept_seen: cover property (accept_req_r ##1 !accept_req_r);
  c_locked_write: cover property (wr_en && addr == CILC_OFS_STATUS && nesting_disable_r);
  c_hold_blocks: cover property (best_vld && interrupt_hold_active);
  c_extended_level: cover property (cpu_priority_msb_r && best_vld && !accept_req_r);

endmodule

//--- cilc_ext_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// External interrupt sources beside the core
// ----------------------------------------
module cilc_ext_src (
  input wire logic clock,
  output logic ext_irq_zero_pin,
  output logic ext_irq_one_pin,
  output logic ext_irq_two_pin
);
  logic [2:0] lvl_r = 3'h0;
  assign ext_irq_zero_pin = lvl_r[0];
  assign ext_irq_one_pin = lvl_r[1];
  assign ext_irq_two_pin = lvl_r[2];
  // Pins move only just after an edge, so sync capture is never ambiguous
  task automatic set_pin(input int i, input logic v);
    @(posedge clock);
    lvl_r[i] <= v;
  endtask
endmodule

//--- test_cpu_interrupt_level_and_edge_control.sv
`timescale 1ns/1ps
module test_cpu_interrupt_level_and_edge_control;
  import cilc_pkg::*;
  logic clock;
  logic rst;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [15:0] rdata_r;
  logic p0;
  logic p1;
  logic p2;
  logic irq_r;
  logic accept_req_r;
  logic [1:0] accept_src_r;
  logic [2:0] accept_prio_r;
  logic alternate_vector_select_r;
  logic [3:0] cpu_level_r;
  int num_errors = 0;
  int check_count = 0;
  int seed = 2006;
  int st = 0;
  int nest = 0;

  cilc_top u_cilc_top (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r), .ext_irq_zero_pin(p0),
    .ext_irq_one_pin(p1), .ext_irq_two_pin(p2), .irq_r(irq_r),
    .accept_req_r(accept_req_r), .accept_src_r(accept_src_r),
    .accept_prio_r(accept_prio_r),
    .alternate_vector_select_r(alternate_vector_select_r),
    .cpu_level_r(cpu_level_r));
  cilc_ext_src u_cilc_ext_src (.clock(clock), .ext_irq_zero_pin(p0),
    .ext_irq_one_pin(p1), .ext_irq_two_pin(p2));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------
  // Bus master, compare and verdict
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    check(rdata_r, exp);
  endtask

  // Model keeps the level field when nesting is disabled
  task automatic wst(input int d);
    wr(CILC_OFS_STATUS, d[15:0]);
    st = (nest != 0) ? ((d & 'h010F) | (st & 'h00E0)) : (d & 'h01EF);
  endtask

  task automatic fire(input int i, input int pol, input int p, input int eff);
    int exp;
    int n;
    exp = (p > eff) ? 1 : 0;
    wr(CILC_OFS_CTL2, 16'(pol << i));
    u_cilc_ext_src.set_pin(i, pol[0]);
    repeat (6) @(posedge clock);
    wr(CILC_OFS_ISTAT, 16'h0007);
    wr(CILC_OFS_IMASK, 16'h0007);
    wr(CILC_OFS_CORE, eff[3] ? 16'h0008 : 16'h0000);
    wst(eff[2:0] << 5);
    wr(CILC_OFS_PRIO, 16'(p << (4 * i)));
    u_cilc_ext_src.set_pin(i, ~pol[0]);
    n = 0;
    irq_r_wait: while (n < 12)
    begin
      @(posedge clock);
      #1;
      if (irq_r === 1'b1)
        break;
      n++;
    end
    if (n == 12)
    begin
      num_errors++;
      give_verdict();
    end
    @(posedge clock);
    #1;
    check(16'(irq_r), 16'h0001);
    check(16'(accept_req_r), 16'(exp));
    check(16'(accept_src_r), exp ? 16'(i) : 16'h0000);
    check(16'(accept_prio_r), exp ? 16'(p) : 16'h0000);
    check(16'(cpu_level_r), 16'(eff));
    rd(CILC_OFS_ISTAT, 16'(1 << i));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(CILC_OFS_STATUS, 16'h0000);
    rd(CILC_OFS_CORE, 16'h0000);
    rd(CILC_OFS_CTL2, 16'h0000);
    rd(CILC_OFS_PRIO, 16'h0444);
    check(16'(cpu_level_r), 16'h0000);
    rd(16'h00A0, 16'h0000);
    wst('hFFFF);
    rd(CILC_OFS_STATUS, st[15:0]);
    check(16'(cpu_level_r), 16'h0007);
    wr(CILC_OFS_CORE, 16'h0008);
    rd(CILC_OFS_CORE, 16'h0008);
    check(16'(cpu_level_r), 16'h000F);
    wr(CILC_OFS_CTL2, 16'hFFFF);
    rd(CILC_OFS_CTL2, 16'h8007);
    check(16'(alternate_vector_select_r), 16'h0001);
    wr(CILC_OFS_CTL1, 16'h8000);
    nest = 1;
    wst('h0000);
    rd(CILC_OFS_STATUS, st[15:0]);
    check(16'(cpu_level_r), 16'h000F);
    wr(CILC_OFS_CTL1, 16'h0000);
    nest = 0;
    wr(CILC_OFS_HOLD, 16'h0014);
    rd(CILC_OFS_CTL2, 16'hC007);
    repeat (30) @(posedge clock);
    rd(CILC_OFS_CTL2, 16'h8007);
    wr(CILC_OFS_CTL2, 16'h0000);
    #1;
    check(16'(alternate_vector_select_r), 16'h0000);
    fire(0, 0, 7, 7);
    fire(1, 1, 7, 8);
    fire(2, 0, 7, 6);
    for (int i = 0; i < 3; i++)
      for (int pol = 0; pol < 2; pol++)
        fire(i, pol, $unsigned($random(seed)) % 8, $unsigned($random(seed)) % 16);
    // Source two is still pending: hold counter and clear withdraw it
    wr(CILC_OFS_CORE, 16'h0000);
    wst('h0000);
    wr(CILC_OFS_PRIO, 16'h0777);
    rd(CILC_OFS_ISTAT, 16'h0004);
    check(16'(accept_req_r), 16'h0001);
    wr(CILC_OFS_HOLD, 16'h0008);
    repeat (2) @(posedge clock);
    #1;
    check(16'(accept_req_r), 16'h0000);
    repeat (10) @(posedge clock);
    #1;
    check(16'(accept_req_r), 16'h0001);
    check(16'(accept_src_r), 16'h0002);
    wr(CILC_OFS_ISTAT, 16'h0004);
    repeat (2) @(posedge clock);
    #1;
    check(16'(irq_r), 16'h0000);
    check(16'(accept_req_r), 16'h0000);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule
